//--- qdsuc_host.sv
// Host serial port model: frames out, serial output captured
`timescale 1ns/1ps
`default_nettype none
module qdsuc_host (
  output logic shift_clk,
  output logic serial_in,
  output logic frame_sel_n,
  input wire logic serial_out
);
  // Idle: clock parked high, frame deselected
  initial begin
    shift_clk = 1'b1;
    serial_in = 1'b0;
    frame_sel_n = 1'b1;
  end
  // Sends n bits MSB first, one bit per 160 ns clock
  task automatic xfer(input logic [47:0] w, input int n, output logic [47:0] rx);
    rx = 48'h0;
    frame_sel_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = w[i];
      #80;
      rx = {rx[46:0], serial_out};
      shift_clk = 1'b0;
      #80;
      shift_clk = 1'b1;
    end
    #80;
    frame_sel_n = 1'b1;
    serial_in = ~serial_in;
    #400;
  endtask : xfer
endmodule : qdsuc_host
`default_nettype wire

//--- qdsuc_map.svh
// Constants for the quad converter serial update control block
`ifndef QDSUC_MAP_SVH
`define QDSUC_MAP_SVH
`define QDSUC_FRAME_BITS 24
`define QDSUC_CNT_W 5
`define QDSUC_CODE_W 14
`define QDSUC_DATA_W 16
`define QDSUC_NCH 4
`define QDSUC_RW_BIT 23
`define QDSUC_RSEL_HI 21
`define QDSUC_RSEL_LO 19
`define QDSUC_CH_HI 18
`define QDSUC_CH_LO 16
`define QDSUC_RSEL_FUNC 3'h0
`define QDSUC_RSEL_DATA 3'h2
`define QDSUC_RSEL_COARSE 3'h3
`define QDSUC_RSEL_FINE 3'h4
`define QDSUC_FUNC_IDLE 3'h0
`define QDSUC_FUNC_CTRL 3'h1
`define QDSUC_FUNC_CLEAR 3'h4
`define QDSUC_FUNC_LOAD 3'h5
`define QDSUC_CH_ALL 3'h4
`define QDSUC_CTRL_W 6
`define QDSUC_SO_DIS_BIT 0
`define QDSUC_FINE_W 6
`define QDSUC_COARSE_W 2
`define QDSUC_ZERO_CODE 14'h0000
`define QDSUC_OFFBIN_CLEAR 14'h0000
`define QDSUC_TWOS_CLEAR 14'h0000
`define QDSUC_AXI_CODE_A 12'h000
`define QDSUC_AXI_CODE_B 12'h004
`define QDSUC_AXI_CODE_C 12'h008
`define QDSUC_AXI_CODE_D 12'h00C
`define QDSUC_AXI_STATUS 12'h010
`define QDSUC_AXI_CTRL 12'h014
`define QDSUC_AXI_LAST 12'h018
`define QDSUC_AXI_OKAY 2'h0
`define QDSUC_AXI_SLVERR 2'h2
`endif

//--- qdsuc_pkg.sv
// Types for the quad converter serial update control block
package qdsuc_pkg;
  typedef logic [13:0] qdsuc_code_t;
  typedef enum logic [1:0] {QDSUC_FR_IDLE, QDSUC_FR_SHIFT} qdsuc_frame_e;
endpackage : qdsuc_pkg

//--- qdsuc_top.sv
// Serial frame decode, register bank, output update and clear for a quad converter
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "qdsuc_map.svh"
module qdsuc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic shift_clk,
  input wire logic serial_in,
  input wire logic frame_sel_n,
  input wire logic load_outputs_n,
  input wire logic clear_outputs_n,
  input wire logic coding_select,
  output logic serial_out,
  output logic serial_out_oe_n,
  output logic [55:0] dac_code,
  output logic [59:0] segment_sw,
  output logic [47:0] ladder_sw,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Thermometer decode of the four top code bits
  function automatic logic [14:0] therm(input logic [3:0] v);
    logic [14:0] t;
    t = '0;
    for (int i = 0; i < 15; i++) begin
      t[i] = (32'(v) > i);
    end
    return t;
  endfunction : therm

  // Clear code chosen by the coding pin
  function automatic qdsuc_pkg::qdsuc_code_t clr_code(input logic offbin);
    // Offset binary clears to negative full scale, twos complement to zero volts
    return offbin ? `QDSUC_OFFBIN_CLEAR : `QDSUC_TWOS_CLEAR;
  endfunction : clr_code

  // Two-flop synchronisers for the six serial and control input pins
  logic [5:0] meta_r;
  logic [5:0] sync_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 6'h3F;
      sync_r <= 6'h3F;
    end else begin
      meta_r <= {shift_clk, serial_in, frame_sel_n, load_outputs_n, clear_outputs_n,
                 coding_select};
      sync_r <= meta_r;
    end
  end
  logic sck_s, sdi_s, fs_s, ld_s, clr_s, cod_s;
  assign {sck_s, sdi_s, fs_s, ld_s, clr_s, cod_s} = sync_r;

  // Previous values for edge detection
  logic sck_d_r, fs_d_r, ld_d_r, clr_d_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_d_r <= 1'b0;
      fs_d_r <= 1'b1;
      ld_d_r <= 1'b1;
      clr_d_r <= 1'b1;
    end else begin
      sck_d_r <= sck_s;
      fs_d_r <= fs_s;
      ld_d_r <= ld_s;
      clr_d_r <= clr_s;
    end
  end
  logic sck_fall, sck_rise, fs_rise, ld_fall, clr_fall;
  assign sck_fall = sck_d_r & ~sck_s & ~fs_s;
  assign sck_rise = ~sck_d_r & sck_s & ~fs_s;
  assign fs_rise = ~fs_d_r & fs_s;
  assign ld_fall = ld_d_r & ~ld_s;
  assign clr_fall = clr_d_r & ~clr_s;

  // Input shift register and falling edge count
  logic [23:0] shreg_r;
  logic [`QDSUC_CNT_W-1:0] cnt_r;
  logic over_r;
  qdsuc_pkg::qdsuc_frame_e fr_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shreg_r <= 24'h000000;
      cnt_r <= '0;
      over_r <= 1'b0;
      fr_r <= qdsuc_pkg::QDSUC_FR_IDLE;
    end else if (fs_s) begin
      cnt_r <= '0;
      over_r <= 1'b0;
      fr_r <= qdsuc_pkg::QDSUC_FR_IDLE;
    end else if (sck_fall) begin
      fr_r <= qdsuc_pkg::QDSUC_FR_SHIFT;
      shreg_r <= {shreg_r[22:0], sdi_s};
      if (cnt_r == 5'(`QDSUC_FRAME_BITS)) begin
        over_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 5'h01;
      end
    end
  end

  // Frame is valid only with exactly 24 edges
  logic frame_ok;
  assign frame_ok = fs_rise && fr_r == qdsuc_pkg::QDSUC_FR_SHIFT &&
                    cnt_r == 5'(`QDSUC_FRAME_BITS) && !over_r;
  logic rw;
  logic [2:0] rsel, chan;
  logic [15:0] fdata;
  assign rw = shreg_r[`QDSUC_RW_BIT];
  assign rsel = shreg_r[`QDSUC_RSEL_HI:`QDSUC_RSEL_LO];
  assign chan = shreg_r[`QDSUC_CH_HI:`QDSUC_CH_LO];
  assign fdata = shreg_r[15:0];
  logic wr_ok;
  assign wr_ok = frame_ok && !rw;

  // Function register control bits, from a serial frame or the register bus
  // A serial frame wins when both arrive in the same cycle
  logic [`QDSUC_CTRL_W-1:0] ctrl_r;
  logic [31:0] wdata_r;
  logic axi_ctrl_wr;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= '0;
    end else if (wr_ok && rsel == `QDSUC_RSEL_FUNC && chan == `QDSUC_FUNC_CTRL) begin
      ctrl_r <= fdata[`QDSUC_CTRL_W-1:0];
    end else if (axi_ctrl_wr) begin
      ctrl_r <= wdata_r[`QDSUC_CTRL_W-1:0];
    end
  end

  // Gain registers per channel, broadcast on the all-channel address
  logic [`QDSUC_FINE_W-1:0] fine_r [4];
  logic [`QDSUC_COARSE_W-1:0] coarse_r [4];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) begin
        fine_r[i] <= '0;
        coarse_r[i] <= '0;
      end
    end else if (wr_ok) begin
      for (int i = 0; i < 4; i++) begin
        if (chan == 3'(i) || chan == `QDSUC_CH_ALL) begin
          if (rsel == `QDSUC_RSEL_FINE) fine_r[i] <= fdata[5:0];
          if (rsel == `QDSUC_RSEL_COARSE) coarse_r[i] <= fdata[1:0];
        end
      end
    end
  end

  // Clear requests from pin edge, pin held low as reset ends, or software command
  logic sw_clear, sw_load;
  assign sw_clear = wr_ok && rsel == `QDSUC_RSEL_FUNC && chan == `QDSUC_FUNC_CLEAR;
  assign sw_load = wr_ok && rsel == `QDSUC_RSEL_FUNC && chan == `QDSUC_FUNC_LOAD;
  logic init_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) init_r <= 1'b1;
    else init_r <= 1'b0;
  end
  logic do_clear;
  assign do_clear = clr_fall || sw_clear || (init_r && !clr_s);

  // Data (input) registers and output latches
  logic [13:0] data_r [4];
  logic [13:0] out_r [4];
  logic data_wr;
  assign data_wr = wr_ok && rsel == `QDSUC_RSEL_DATA;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) data_r[i] <= `QDSUC_ZERO_CODE;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (do_clear) begin
          data_r[i] <= clr_code(cod_s);
        end else if (data_wr && (chan == 3'(i) || chan == `QDSUC_CH_ALL)) begin
          data_r[i] <= fdata[15:2];
        end
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) out_r[i] <= `QDSUC_ZERO_CODE;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (do_clear) begin
          out_r[i] <= clr_code(cod_s);
        end else if (ld_fall || sw_load) begin
          out_r[i] <= data_r[i];
        end else if (data_wr && !ld_s && (chan == 3'(i) || chan == `QDSUC_CH_ALL)) begin
          out_r[i] <= fdata[15:2];
        end
      end
    end
  end

  // Code fan-out and switch decode, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_code <= '0;
      segment_sw <= '0;
      ladder_sw <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        dac_code[i*14 +: 14] <= out_r[i];
        // Offset-binary ladder code; twos complement flips the sign bit
        segment_sw[i*15 +: 15] <= therm({out_r[i][13] ^ ~cod_s, out_r[i][12:10]});
        ladder_sw[i*12 +: 12] <= {out_r[i][9:0], 2'b00};
      end
    end
  end

  // Readback selection latched from a read frame
  logic [23:0] rb_r;
  logic rb_pend_r;
  logic [15:0] rb_val;
  logic [1:0] ci;
  assign ci = chan[1:0];
  always_comb begin
    rb_val = 16'h0000;
    unique case (rsel)
      `QDSUC_RSEL_DATA: rb_val = {data_r[ci], 2'b00};
      `QDSUC_RSEL_COARSE: rb_val = {14'h0000, coarse_r[ci]};
      `QDSUC_RSEL_FINE: rb_val = {10'h000, fine_r[ci]};
      `QDSUC_RSEL_FUNC: rb_val = {10'h000, ctrl_r};
      default: rb_val = 16'h0000;
    endcase
  end

  // Serial output: readback word or ripple of the shift register MSB
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rb_r <= 24'h000000;
      rb_pend_r <= 1'b0;
      serial_out <= 1'b0;
      serial_out_oe_n <= 1'b0;
    end else begin
      serial_out_oe_n <= ctrl_r[`QDSUC_SO_DIS_BIT];
      // Readback MSB must already stand before the first falling shift clock
      if (frame_ok && rw) begin
        rb_r <= {shreg_r[22:16], rb_val, 1'b0};
        serial_out <= shreg_r[23];
        rb_pend_r <= 1'b1;
      end else if (fs_rise) begin
        rb_pend_r <= 1'b0;
      end
      // Later bits move out on each rising shift clock
      if (sck_rise) begin
        if (rb_pend_r) begin
          serial_out <= rb_r[23];
          rb_r <= {rb_r[22:0], 1'b0};
        end else begin
          serial_out <= shreg_r[23];
        end
      end
    end
  end

  // Register slave: channel codes, status and control
  logic aw_r, w_r;
  logic [11:0] awaddr_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `QDSUC_AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      // Write data is kept until the address has also arrived
      if (s_axi_wvalid && s_axi_wready) begin
        w_r <= 1'b1;
        wdata_r <= s_axi_wdata;
      end
      if (aw_r && w_r && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r < `QDSUC_AXI_LAST) ? `QDSUC_AXI_OKAY : `QDSUC_AXI_SLVERR;
        aw_r <= 1'b0;
        w_r <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_r && !s_axi_bvalid;
  // Control register write lands as the answer is raised
  assign axi_ctrl_wr = aw_r && w_r && !s_axi_bvalid &&
                       (awaddr_r & 12'hFFC) == `QDSUC_AXI_CTRL;
  assign s_axi_wready = !w_r && !s_axi_bvalid;

  // Read channel, one cycle after address acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `QDSUC_AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `QDSUC_AXI_OKAY;
      unique case (s_axi_araddr & 12'hFFC)
        `QDSUC_AXI_CODE_A: s_axi_rdata <= {18'h00000, out_r[0]};
        `QDSUC_AXI_CODE_B: s_axi_rdata <= {18'h00000, out_r[1]};
        `QDSUC_AXI_CODE_C: s_axi_rdata <= {18'h00000, out_r[2]};
        `QDSUC_AXI_CODE_D: s_axi_rdata <= {18'h00000, out_r[3]};
        `QDSUC_AXI_STATUS: s_axi_rdata <= {26'h0000000, rb_pend_r, cod_s, fr_r == qdsuc_pkg::QDSUC_FR_SHIFT, cnt_r[2:0] == 3'h0 ? 1'b0 : 1'b1, ld_s, clr_s};
        `QDSUC_AXI_CTRL: s_axi_rdata <= {26'h0000000, ctrl_r};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `QDSUC_AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

endmodule : qdsuc_top
`default_nettype wire

//--- qdsuc_top_monitor.sv
// Bus and output checks for the converter control block
`timescale 1ns/1ps
`default_nettype none
module qdsuc_mon (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear_outputs_n,
  input wire logic coding_select,
  input wire logic [55:0] dac_code,
  input wire logic [59:0] segment_sw,
  input wire logic [47:0] ladder_sw,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Clear pin forces every code to the cleared value
  clr_code_a: assert property ($fell(clear_outputs_n) ##1 !clear_outputs_n
    |-> ##[1:6] dac_code == 56'h0) else $error("clear not applied");
  // Ladder and segment switches follow a settled code
  lad_a: assert property ($stable(dac_code)[*2]
    |-> ladder_sw[11:0] == {dac_code[9:0], 2'h0}) else $error("ladder mismatch");
  seg_a: assert property (coding_select && $stable({coding_select, dac_code})[*3]
    |-> segment_sw[14:0] == ~(15'h7FFF << dac_code[13:10])) else $error("segment mismatch");
  // Bus answers and their holding
  wr_ans_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  rd_ans_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 12'h018
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property ($fell(clear_outputs_n));
endmodule : qdsuc_mon
bind qdsuc_top qdsuc_mon mon (.aclk, .aresetn, .clear_outputs_n, .coding_select, .dac_code,
  .segment_sw, .ladder_sw, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

//--- qdsuc_top_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "qdsuc_map.svh"
module qdsuc_top_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic load_outputs_n = 1'b0;
  logic clear_outputs_n = 1'b0;
  logic coding_select = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic shift_clk, serial_in, frame_sel_n, serial_out, oe_n;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [55:0] dac_code;
  logic [59:0] segment_sw;
  logic [47:0] ladder_sw, rx;
  int errors = 0;
  int total_checks = 0;
  always #2.5 aclk = ~aclk;
  qdsuc_host host (.shift_clk(shift_clk), .serial_in(serial_in), .frame_sel_n(frame_sel_n),
    .serial_out(serial_out));
  qdsuc_top uut (.aclk(aclk), .aresetn(aresetn), .shift_clk(shift_clk), .serial_in(serial_in),
    .frame_sel_n(frame_sel_n), .load_outputs_n(load_outputs_n), .clear_outputs_n(clear_outputs_n),
    .coding_select(coding_select), .serial_out(serial_out), .serial_out_oe_n(oe_n),
    .dac_code(dac_code), .segment_sw(segment_sw), .ladder_sw(ladder_sw),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // Comparison and verdict
  task automatic check(input string what, input logic [55:0] seen, input logic [55:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  // Bus write: address and data released as each is taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    int k;
    logic ta, tw;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      resp = bresp;
      if (bvalid) break;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    @(posedge aclk);
    bready <= 1'b0;
    if (k == 40) begin
      errors++;
      conclude();
    end
  endtask : axi_wr
  // Bus read: address held until taken, data taken with rvalid
  task automatic axi_rd(input logic [11:0] a);
    int k;
    logic ta;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(negedge aclk);
      ta = arvalid && arready;
      rd = rdata;
      resp = rresp;
      if (rvalid) break;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    @(posedge aclk);
    arvalid <= 1'b0;
    rready <= 1'b0;
    if (k == 40) begin
      errors++;
      conclude();
    end
  endtask : axi_rd
  function automatic logic [47:0] mk(logic rw, logic [2:0] s, logic [2:0] c, logic [15:0] d);
    return {24'h0, rw, 1'b0, s, c, d};
  endfunction : mk
  task automatic frame(input logic [47:0] w, input int n);
    host.xfer(w, n, rx);
    @(posedge aclk);
  endtask : frame
  // Individual update, decode and register bus
  task automatic t_single();
    frame(mk(0, `QDSUC_RSEL_DATA, 3'h0, {14'h3A5C, 2'h0}), 24);
    check("code a", dac_code[13:0], 14'h3A5C);
    check("segments a", segment_sw[14:0], 15'h3FFF);
    check("ladder a", ladder_sw[11:0], 12'h970);
    axi_rd(`QDSUC_AXI_CODE_A);
    check("bus code a", rd, 32'h00003A5C);
    frame(mk(0, `QDSUC_RSEL_DATA, 3'h1, {14'h1111, 2'h0}), 23);
    frame(mk(0, `QDSUC_RSEL_DATA, 3'h1, {14'h1111, 2'h0}) << 1, 25);
    check("short or long frame", dac_code[27:14], 14'h0);
    axi_rd(`QDSUC_AXI_LAST);
    check("unmapped resp", resp, `QDSUC_AXI_SLVERR);
    axi_wr(`QDSUC_AXI_CTRL, 32'h1);
    check("write resp", resp, `QDSUC_AXI_OKAY);
    repeat (4) @(posedge aclk);
    check("output disabled", oe_n, 1'b1);
    axi_wr(`QDSUC_AXI_CTRL, 32'h0);
    $display("test single done");
  endtask : t_single
  // Deferred update on load strobe, ripple and readback
  task automatic t_load_read();
    load_outputs_n <= 1'b1;
    frame(mk(0, `QDSUC_RSEL_DATA, 3'h2, {14'h1234, 2'h0}), 24);
    check("code c held", dac_code[41:28], 14'h0);
    load_outputs_n <= 1'b0;
    repeat (8) @(posedge aclk);
    check("code c loaded", dac_code[41:28], 14'h1234);
    frame(48'hC3A5F0_5A0F96, 48);
    check("ripple", rx[23:0], 24'hC3A5F0);
    frame(mk(0, `QDSUC_RSEL_FINE, 3'h0, 16'h002A), 24);
    frame(48'hA00000, 24);
    frame(48'h000000, 24);
    check("fine readback", rx[15:0], 16'h002A);
    $display("test load and read done");
  endtask : t_load_read
  // Clear by pin under twos complement coding and by command under offset binary coding
  task automatic t_clear();
    coding_select <= 1'b0;
    clear_outputs_n <= 1'b0;
    repeat (10) @(posedge aclk);
    check("pin clear", dac_code, 56'h0);
    clear_outputs_n <= 1'b1;
    repeat (20) @(posedge aclk);
    check("clear held", dac_code, 56'h0);
    frame(mk(0, `QDSUC_RSEL_DATA, 3'h3, {14'h0777, 2'h0}), 24);
    check("code d", dac_code[55:42], 14'h0777);
    coding_select <= 1'b1;
    frame(48'h040000, 24);
    check("command clear", dac_code, 56'h0);
    $display("test clear done");
  endtask : t_clear
  // Reset with clear held low, then the scenarios
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    check("reset codes", dac_code, 56'h0);
    check("output enabled", oe_n, 1'b0);
    clear_outputs_n <= 1'b1;
    repeat (4) @(posedge aclk);
    t_single();
    t_load_read();
    t_clear();
    conclude();
  end
endmodule : qdsuc_top_tb
`default_nettype wire
